// ==== verification/dmbi_ctrl_model.sv ====
`timescale 1ns/1ns
module dmbi_ctrl_model (
  input  wire logic                  link_clk, // data interface clock
  output      dmbi_pkg::dmbi_wbeat_t wr_beat   // beat onto the pins
);
  import dmbi_pkg::*;
  // ****************************************
  // controller drive of the write pins
  // ****************************************
  // quiet bus from time zero
  initial begin
    wr_beat = '0;
  end
  // one beat: byte per lane, active-low flag beside it
  task automatic beat(input logic [15:0] dq, input logic [1:0] fl);
    @(posedge link_clk);
    wr_beat <= {1'b1, dq, fl};
  endtask
  // released pins show the inverse, so stale data cannot pass
  task automatic idle();
    @(posedge link_clk);
    wr_beat <= {1'b0, ~wr_beat.dq, ~wr_beat.flag_n};
  endtask
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  import dmbi_pkg::*;
  logic        pclk, link_clk, presetn, psel, penable, pwrite;
  logic        pready, pslverr, term_strobe_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  flag_rx_en;
  logic        er;
  dmbi_wbeat_t wr_beat;
  dmbi_cbeat_t core_wr;
  dmbi_rbeat_t core_rd;
  dmbi_pbeat_t pin_rd;
  int          err_total, n_checks, cyc;

  // ****************************************
  // clocks, instances, watchdog
  // ****************************************
  // two unrelated clocks, link offset by 7 ns
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  dmbi_lanes DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .wr_beat(wr_beat), .core_wr(core_wr),
    .core_rd(core_rd), .pin_rd(pin_rd), .flag_rx_en(flag_rx_en),
    .term_strobe_en(term_strobe_en));
  dmbi_ctrl_model ctrl (.link_clk(link_clk), .wr_beat(wr_beat));
  // a hang counts as a mismatch
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      conclude();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no timeout of its own; only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // m5 is {read inv, write inv, mask}; st the expected status nibble
  task automatic cfg(input logic [1:0] org, input logic ts,
                     input logic [2:0] m5, input logic [3:0] st);
    int n;
    apb(1'b1, DMBI_ORG_OFS, {30'h0, org});
    apb(1'b1, DMBI_MR1_OFS, 32'(ts) << DMBI_TS_BIT);
    apb(1'b1, DMBI_MR5_OFS, 32'(m5) << DMBI_WMASK_BIT);
    n = 0;
    do begin
      apb(1'b0, DMBI_STATUS_OFS, 32'h0);
      n++;
    end while (rd[DMBI_ST_BUSY] !== 1'b0 && n < 50);
    repeat (3) @(posedge link_clk);
    chk(rd[3:0], st);
  endtask
  // eight back-to-back write beats, judged one beat behind
  task automatic wburst(input logic msk, input logic inv,
                        input logic [1:0] ln);
    logic [15:0] dq[8], ed, cm;
    logic [1:0]  fl[8], eb;
    int          i, l;
    for (i = 0; i <= 8; i++) begin
      if (i < 8) begin
        dq[i] = {8'(i * 37), 8'(8'hf0 + i * 29)};
        fl[i] = 2'(i);
        ctrl.beat(dq[i], fl[i]);
      end else ctrl.idle();
      @(negedge link_clk);
      if (i > 0) begin
        for (l = 0; l < 2; l++) begin
          eb[l] = ln[l] & ~(msk & ~fl[i-1][l]);
          ed[l*8 +: 8] = (inv & ~fl[i-1][l]) ? ~dq[i-1][l*8 +: 8]
                                             : dq[i-1][l*8 +: 8];
        end
        cm = {{8{eb[1]}}, {8{eb[0]}}};
        chk(core_wr.valid, 1'b1);
        chk(core_wr.byte_en, eb);
        chk(core_wr.data & cm, ed & cm);
      end
    end
    chk(flag_rx_en, (msk | inv) ? ln : 2'b00);
  endtask
  // eight read beats; 0x0f and 0x07 sit either side of the limit
  task automatic rburst(input logic ri, input logic [1:0] ln);
    logic [15:0] dt[8], eq, cm;
    logic [1:0]  ef, lv;
    logic        iv;
    int          i, l;
    lv = ln & {2{ri}};
    cm = {{8{ln[1]}}, {8{ln[0]}}};
    for (i = 0; i <= 8; i++) begin
      @(posedge link_clk);
      dt[i % 8] = {8'(i * 53), 8'h0f >> (i % 2)};
      core_rd <= {(i < 8), (i < 8) ? dt[i % 8] : ~core_rd.data};
      @(negedge link_clk);
      if (i > 0) begin
        for (l = 0; l < 2; l++) begin
          iv = lv[l] & ((8 - $countones(dt[i-1][l*8 +: 8])) > 4);
          eq[l*8 +: 8] = iv ? ~dt[i-1][l*8 +: 8] : dt[i-1][l*8 +: 8];
          ef[l] = ~iv;
        end
        chk(pin_rd.dq_oe, 1'b1);
        chk(pin_rd.flag_oe, lv);
        chk(pin_rd.dq & cm, eq & cm);
        chk(pin_rd.flag_n & lv, ef & lv);
      end
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    err_total = 0;
    n_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    core_rd = '0;
    repeat (20) @(posedge pclk);
    chk(pin_rd.flag_n, 2'b11);
    presetn <= 1'b1;
    apb(1'b0, DMBI_MR1_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, DMBI_MR5_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, DMBI_ORG_OFS, 32'h0);
    chk(rd, {30'h0, DMBI_ORG_RST});
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    cfg(2'h2, 1'b0, 3'b001, 4'b0001);
    wburst(1'b1, 1'b0, 2'b11);
    cfg(2'h2, 1'b0, 3'b110, 4'b0110);
    wburst(1'b0, 1'b1, 2'b11);
    rburst(1'b1, 2'b11);
    cfg(2'h2, 1'b0, 3'b000, 4'b0000);
    wburst(1'b0, 1'b0, 2'b11);
    rburst(1'b0, 2'b11);
    cfg(2'h1, 1'b1, 3'b100, 4'b1000);
    chk(term_strobe_en, 1'b1);
    wburst(1'b0, 1'b0, 2'b01);
    rburst(1'b0, 2'b01);
    cfg(2'h0, 1'b1, 3'b101, 4'b0000);
    chk(term_strobe_en, 1'b0);
    wburst(1'b0, 1'b0, 2'b01);
    rburst(1'b0, 2'b01);
    conclude();
  end
endmodule

// ==== verilog/dmbi_lanes.sv ====
`timescale 1ns/1ns
// Summary of operation
// - four-bit organization offers neither write masking nor bus inversion
// - termination strobe exists only in the byte-wide organization
// - one shared active-low pin per lane carries mask, inversion or strobe
// - as termination strobe the device drives no level on the shared pin
// - enables: one-A11 strobe; five-A12 read inv, A11 write inv, A10 mask
// - no write mask and no write inversion: receiver off, pin ignored
// - reads use inversion only; read inversion off means driver off
// - termination strobe enabled disables mask and both inversions
// - strobe enabled: termination applied as on the data strobe pair
// - write mask: pin low discards lane byte, pin high stores it
// - write inversion: pin low inverts lane byte, pin high keeps it
// - read inversion: more than four zeros inverts byte and drives pin low
// - burst has eight beats, each a byte plus one flag bit
// - sixteen-bit: low byte pairs lower pin, high byte pairs upper pin
module dmbi_lanes (
  input  wire logic                  pclk,           // apb clock
  input  wire logic                  presetn,        // async reset, low
  input  wire logic                  psel,           // apb select
  input  wire logic                  penable,        // apb access phase
  input  wire logic                  pwrite,         // apb direction
  input  wire logic [7:0]            paddr,          // apb byte address
  input  wire logic [31:0]           pwdata,         // apb write data
  output      logic [31:0]           prdata,         // apb read data
  output      logic                  pready,         // apb ready
  output      logic                  pslverr,        // apb error
  input  wire logic                  link_clk,       // data interface clock
  input  wire dmbi_pkg::dmbi_wbeat_t wr_beat,        // write beat from pins
  output      dmbi_pkg::dmbi_cbeat_t core_wr,        // write beat to core
  input  wire dmbi_pkg::dmbi_rbeat_t core_rd,        // read beat from core
  output      dmbi_pkg::dmbi_pbeat_t pin_rd,         // read beat to pins
  output      logic [1:0]            flag_rx_en,     // shared pin receivers
  output      logic                  term_strobe_en  // strobe termination on
);
  import dmbi_pkg::*;

  // ********************************************************
  // helpers
  // ********************************************************

  // lane is populated in the given organization
  function automatic logic lane_on(input dmbi_org_t org, input int lane);
    lane_on = (org == DMBI_ORG_X16) || (org == DMBI_ORG_X8 && lane == 0);
  endfunction

  // more than four zero bits in a byte
  function automatic logic many_zeros(input logic [7:0] b);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, ~b[i]};
    end
    many_zeros = n > DMBI_ZERO_LIMIT;
  endfunction

  // effective enables from mode images and organization
  function automatic dmbi_cfg_t eff_cfg(input logic [15:0] m1,
                                        input logic [15:0] m5,
                                        input dmbi_org_t   org);
    dmbi_cfg_t c;
    c       = '0;
    c.org   = org;
    c.ts    = m1[DMBI_TS_BIT] && org == DMBI_ORG_X8;
    if (!c.ts && lane_on(org, 0)) begin
      c.rinv  = m5[DMBI_RINV_BIT];
      c.wmask = m5[DMBI_WMASK_BIT];
      // mask wins if the controller sets both anyway
      c.winv  = m5[DMBI_WINV_BIT] && !m5[DMBI_WMASK_BIT];
    end
    eff_cfg = c;
  endfunction

  // ********************************************************
  // apb side
  // ********************************************************
  typedef struct packed {
    logic [15:0] mr1;
    logic [15:0] mr5;
    dmbi_org_t   org;
    dmbi_cfg_t   hold;    // word handed to the link, stable while busy
    logic        req_tog;
    logic        ack_s1;
    logic        ack_s2;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dmbi_apb_t;

  dmbi_apb_t a_r;
  dmbi_apb_t a_nxt;
  logic      ack_tog;     // from link domain
  logic      a_busy;
  dmbi_cfg_t a_want;
  logic      a_hit;

  // register access, zero-wait answer in the access phase
  always_comb begin
    a_nxt   = a_r;
    a_busy  = a_r.req_tog != a_r.ack_s2;
    a_want  = eff_cfg(a_r.mr1, a_r.mr5, a_r.org);
    a_hit   = paddr == DMBI_MR1_OFS || paddr == DMBI_MR5_OFS ||
              paddr == DMBI_ORG_OFS || paddr == DMBI_STATUS_OFS;
    a_nxt.ack_s1  = ack_tog;
    a_nxt.ack_s2  = a_r.ack_s1;
    a_nxt.pready  = psel && !penable;
    a_nxt.pslverr = psel && !penable && !a_hit;
    a_nxt.prdata  = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        DMBI_MR1_OFS: a_nxt.prdata = {16'h0000, a_r.mr1};
        DMBI_MR5_OFS: a_nxt.prdata = {16'h0000, a_r.mr5};
        DMBI_ORG_OFS: a_nxt.prdata = {30'h0, a_r.org};
        DMBI_STATUS_OFS: begin
          a_nxt.prdata[DMBI_ST_WMASK] = a_want.wmask;
          a_nxt.prdata[DMBI_ST_WINV]  = a_want.winv;
          a_nxt.prdata[DMBI_ST_RINV]  = a_want.rinv;
          a_nxt.prdata[DMBI_ST_TS]    = a_want.ts;
          // a pending word not yet launched counts as busy as well
          a_nxt.prdata[DMBI_ST_BUSY]  = a_busy || a_want != a_r.hold;
          a_nxt.prdata[DMBI_ST_CONFL] = a_r.mr5[DMBI_WINV_BIT] &&
                                        a_r.mr5[DMBI_WMASK_BIT];
        end
        default: a_nxt.prdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite && a_r.pready) begin
      unique case (paddr)
        DMBI_MR1_OFS: a_nxt.mr1 = pwdata[15:0];
        DMBI_MR5_OFS: a_nxt.mr5 = pwdata[15:0];
        DMBI_ORG_OFS: a_nxt.org = dmbi_org_t'(pwdata[1:0]);
        default: a_nxt.org = a_r.org;
      endcase
    end
    // launch a new word only once the last one was taken
    if (!a_busy && a_want != a_r.hold) begin
      a_nxt.hold    = a_want;
      a_nxt.req_tog = !a_r.req_tog;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_r        <= '0;
      a_r.org    <= dmbi_org_t'(DMBI_ORG_RST);
      a_r.hold   <= '0;
    end else begin
      a_r <= a_nxt;
    end
  end

  assign prdata  = a_r.prdata;
  assign pready  = a_r.pready;
  assign pslverr = a_r.pslverr;

  // ********************************************************
  // link side
  // ********************************************************
  typedef struct packed {
    logic        req_s1;
    logic        req_s2;
    logic        ack_tog;
    dmbi_cfg_t   cfg;
    dmbi_cbeat_t cw;
    dmbi_pbeat_t pr;
    logic [1:0]  rx_en;
    logic        term;
  } dmbi_lnk_t;

  dmbi_lnk_t l_r;
  dmbi_lnk_t l_nxt;

  // per beat, per lane coding; no state kept between beats
  always_comb begin
    l_nxt        = l_r;
    l_nxt.req_s1 = a_r.req_tog;
    l_nxt.req_s2 = l_r.req_s1;
    // hold word is stable while the toggle is outstanding
    if (l_r.req_s2 != l_r.ack_tog) begin
      l_nxt.cfg     = a_r.hold;
      l_nxt.ack_tog = l_r.req_s2;
    end
    l_nxt.term       = l_r.cfg.ts;
    l_nxt.cw.valid   = wr_beat.valid;
    l_nxt.cw.data    = wr_beat.dq;
    l_nxt.cw.byte_en = 2'b00;
    l_nxt.pr.dq      = core_rd.data;
    l_nxt.pr.dq_oe   = core_rd.valid;
    l_nxt.pr.flag_n  = 2'b11;
    l_nxt.pr.flag_oe = 2'b00;
    for (int l = 0; l < 2; l++) begin
      l_nxt.rx_en[l] = lane_on(l_r.cfg.org, l) &&
                       (l_r.cfg.wmask || l_r.cfg.winv);
      if (l_r.cfg.org == DMBI_ORG_X4) begin
        l_nxt.cw.byte_en[l] = (l == 0);
      end else if (lane_on(l_r.cfg.org, l)) begin
        // pin level only read when the receiver is on
        if (l_r.cfg.wmask) begin
          l_nxt.cw.byte_en[l] = wr_beat.flag_n[l];
        end else begin
          l_nxt.cw.byte_en[l] = 1'b1;
        end
        if (l_r.cfg.winv && !wr_beat.flag_n[l]) begin
          l_nxt.cw.data[l*8 +: 8] = ~wr_beat.dq[l*8 +: 8];
        end
        if (l_r.cfg.rinv) begin
          l_nxt.pr.flag_oe[l] = core_rd.valid;
          if (many_zeros(core_rd.data[l*8 +: 8])) begin
            l_nxt.pr.dq[l*8 +: 8] = ~core_rd.data[l*8 +: 8];
            l_nxt.pr.flag_n[l]    = 1'b0;
          end
        end
      end
    end
    if (!wr_beat.valid) begin
      l_nxt.cw.byte_en = 2'b00;
    end
  end

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      l_r         <= '0;
      l_r.pr.flag_n <= 2'b11;
    end else begin
      l_r <= l_nxt;
    end
  end

  assign ack_tog        = l_r.ack_tog;
  assign core_wr        = l_r.cw;
  assign pin_rd         = l_r.pr;
  assign flag_rx_en     = l_r.rx_en;
  assign term_strobe_en = l_r.term;

  // ********************************************************
  // checks
  // ********************************************************
  // write path; consequents look at the beat sampled one edge earlier
  a_mask_drop: assert property (@(posedge link_clk)
    disable iff (!presetn)
    l_r.cfg.wmask && wr_beat.valid && !wr_beat.flag_n[0]
    |=> !core_wr.byte_en[0])
    else $error("masked byte was stored");
  a_mask_keep: assert property (@(posedge link_clk)
    disable iff (!presetn)
    l_r.cfg.wmask && wr_beat.valid && wr_beat.flag_n[0]
    |=> core_wr.byte_en[0] && core_wr.data[7:0] == $past(wr_beat.dq[7:0]))
    else $error("unmasked byte lost or changed");
  a_mask_up: assert property (@(posedge link_clk)
    disable iff (!presetn)
    l_r.cfg.wmask && l_r.cfg.org == DMBI_ORG_X16 &&
    wr_beat.valid && !wr_beat.flag_n[1]
    |=> !core_wr.byte_en[1])
    else $error("masked upper byte was stored");
  a_winv_data: assert property (@(posedge link_clk)
    disable iff (!presetn)
    l_r.cfg.winv && wr_beat.valid && !wr_beat.flag_n[0]
    |=> core_wr.data[7:0] == ~$past(wr_beat.dq[7:0]))
    else $error("write byte not inverted");
  a_idle_beat: assert property (@(posedge link_clk)
    disable iff (!presetn)
    !wr_beat.valid
    |=> !core_wr.valid && core_wr.byte_en == 2'b00)
    else $error("core write without a beat");
  a_x4_lane: assert property (@(posedge link_clk)
    disable iff (!presetn)
    l_r.cfg.org == DMBI_ORG_X4 && wr_beat.valid
    |=> core_wr.byte_en == 2'b01 && core_wr.data == $past(wr_beat.dq))
    else $error("four-bit write altered");

  // read path
  a_rinv_low: assert property (@(posedge link_clk)
    disable iff (!presetn)
    l_r.cfg.rinv && core_rd.valid
    |=> pin_rd.flag_n[0] == !many_zeros($past(core_rd.data[7:0])))
    else $error("lower read flag wrong");
  a_rinv_up: assert property (@(posedge link_clk)
    disable iff (!presetn)
    l_r.cfg.rinv && l_r.cfg.org == DMBI_ORG_X16 && core_rd.valid
    |=> pin_rd.flag_n[1] == !many_zeros($past(core_rd.data[15:8])))
    else $error("upper read flag wrong");
  a_rinv_flip: assert property (@(posedge link_clk)
    disable iff (!presetn)
    l_r.cfg.rinv && core_rd.valid && many_zeros(core_rd.data[7:0])
    |=> pin_rd.dq[7:0] == ~$past(core_rd.data[7:0]))
    else $error("read byte not inverted");
  a_rinv_keep: assert property (@(posedge link_clk)
    disable iff (!presetn)
    l_r.cfg.rinv && core_rd.valid && !many_zeros(core_rd.data[7:0])
    |=> pin_rd.dq[7:0] == $past(core_rd.data[7:0]))
    else $error("read byte inverted needlessly");
  a_drv_off: assert property (@(posedge link_clk)
    disable iff (!presetn)
    !l_r.cfg.rinv
    |=> pin_rd.flag_oe == 2'b00)
    else $error("flag driven with read inversion off");

  // pin ownership and organisation
  a_rx_off: assert property (@(posedge link_clk)
    disable iff (!presetn)
    !(l_r.cfg.wmask || l_r.cfg.winv)
    |=> flag_rx_en == 2'b00)
    else $error("receiver on with no write function");
  a_rx_on: assert property (@(posedge link_clk)
    disable iff (!presetn)
    (l_r.cfg.wmask || l_r.cfg.winv) && l_r.cfg.org == DMBI_ORG_X16
    |=> flag_rx_en == 2'b11)
    else $error("receiver off with a write function");
  a_term_quiet: assert property (@(posedge link_clk)
    disable iff (!presetn)
    l_r.cfg.ts
    |=> term_strobe_en && pin_rd.flag_oe == 2'b00 && flag_rx_en == 2'b00)
    else $error("shared pin active as strobe");
  a_x4_none: assert property (@(posedge link_clk)
    disable iff (!presetn)
    l_r.cfg.org == DMBI_ORG_X4
    |=> flag_rx_en == 2'b00 && pin_rd.flag_oe == 2'b00)
    else $error("four-bit part uses shared pin");
  a_ts_x8: assert property (@(posedge link_clk)
    disable iff (!presetn)
    l_r.cfg.org != DMBI_ORG_X8
    |=> !term_strobe_en)
    else $error("strobe outside byte-wide part");
  a_ts_excl: assert property (@(posedge link_clk)
    disable iff (!presetn)
    l_r.cfg.ts
    |-> !(l_r.cfg.wmask || l_r.cfg.winv || l_r.cfg.rinv))
    else $error("strobe with mask or inversion");

  // main scenarios the bench is meant to reach
  c_mask_beat: cover property (@(posedge link_clk) disable iff (!presetn)
    l_r.cfg.wmask && wr_beat.valid && !wr_beat.flag_n[0]);
  c_winv_beat: cover property (@(posedge link_clk) disable iff (!presetn)
    l_r.cfg.winv && wr_beat.valid && !wr_beat.flag_n[1]);
  c_rinv_beat: cover property (@(posedge link_clk) disable iff (!presetn)
    l_r.cfg.rinv && core_rd.valid && many_zeros(core_rd.data[7:0]));
  c_term: cover property (@(posedge link_clk) disable iff (!presetn)
    l_r.cfg.ts);
  c_x4_beat: cover property (@(posedge link_clk) disable iff (!presetn)
    l_r.cfg.org == DMBI_ORG_X4 && wr_beat.valid);

endmodule

// ==== verilog/dmbi_pkg.sv ====
package dmbi_pkg;

  // ********************************************************
  // register map, byte addresses on the apb side
  // ********************************************************
  localparam logic [7:0] DMBI_MR1_OFS    = 8'h00; // mode_register_one image
  localparam logic [7:0] DMBI_MR5_OFS    = 8'h04; // mode_register_five image
  localparam logic [7:0] DMBI_ORG_OFS    = 8'h08; // device organization
  localparam logic [7:0] DMBI_STATUS_OFS = 8'h0c; // effective functions

  // field positions
  localparam int DMBI_TS_BIT    = 11; // mode_register_one A11
  localparam int DMBI_RINV_BIT  = 12; // mode_register_five A12
  localparam int DMBI_WINV_BIT  = 11; // mode_register_five A11
  localparam int DMBI_WMASK_BIT = 10; // mode_register_five A10

  // status field positions
  localparam int DMBI_ST_WMASK  = 0;
  localparam int DMBI_ST_WINV   = 1;
  localparam int DMBI_ST_RINV   = 2;
  localparam int DMBI_ST_TS     = 3;
  localparam int DMBI_ST_BUSY   = 4;
  localparam int DMBI_ST_CONFL  = 5;

  // reset values
  localparam logic       DMBI_EN_RST    = 1'b0;
  localparam logic [1:0] DMBI_ORG_RST   = 2'h2; // sixteen-bit

  // inversion threshold on zero bits per byte
  localparam logic [3:0] DMBI_ZERO_LIMIT = 4'h4;

  // organization codes as written by software
  typedef enum logic [1:0] {
    DMBI_ORG_X4  = 2'h0,
    DMBI_ORG_X8  = 2'h1,
    DMBI_ORG_X16 = 2'h2,
    DMBI_ORG_BAD = 2'h3
  } dmbi_org_t;

  // effective per-device function enables
  typedef struct packed {
    dmbi_org_t org;
    logic      ts;    // termination_strobe
    logic      rinv;  // read bus_inversion_flag
    logic      winv;  // write bus_inversion_flag
    logic      wmask; // write_mask
  } dmbi_cfg_t;

  // write beat from the link
  typedef struct packed {
    logic        valid;
    logic [15:0] dq;
    logic [1:0]  flag_n; // shared pins sampled, [0] lower lane
  } dmbi_wbeat_t;

  // write beat to the core
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic [1:0]  byte_en;
  } dmbi_cbeat_t;

  // read beat from the core
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } dmbi_rbeat_t;

  // read beat onto the pins
  typedef struct packed {
    logic [15:0] dq;
    logic        dq_oe;
    logic [1:0]  flag_n;
    logic [1:0]  flag_oe;
  } dmbi_pbeat_t;

endpackage
